// >>> verilog/spc_pkg.sv
// spc_pkg: constants, carrier structs and state encoding for the serializer power/clock control.
// assumes a 100 MHz reference clock and a 24-bit pixel word carried over 2 or 3 lanes.
package spc_pkg;
  localparam int          REF_PERIOD_NS     = 10;     // reference clock period
  localparam int          PIX_PERIOD_MAX_NS = 100;    // slowest pixel clock served by the stop detector
  localparam int          STOP_GAP_PERIODS  = 4;      // least pixel clock stop gap
  // timeout rounds up so that it never ends before the least gap
  localparam int          STOP_TIMEOUT_CYC  = (STOP_GAP_PERIODS * PIX_PERIOD_MAX_NS + REF_PERIOD_NS - 1)
                                              / REF_PERIOD_NS;
  localparam int          CLK_ALIVE_EDGES   = 2;      // pixel clock edges seen before power-up
  localparam int          LINK_MAX_MHZ      = 80;     // highest link clock the host may cause
  localparam int          PIX_W             = 24;     // pixel word width
  localparam logic [2:0]  LANE_CFG_2        = 3'h2;   // two lanes, value after reset
  localparam logic [2:0]  LANE_CFG_3        = 3'h4;   // three lanes
  localparam logic [2:0]  MULT_2LANE        = 3'h6;   // link clock multiplier, two lanes
  localparam logic [2:0]  MULT_3LANE        = 3'h4;   // link clock multiplier, three lanes
  localparam logic [4:0]  SHIFT_2LANE       = 5'h04;  // bits per link cycle, two lanes
  localparam logic [4:0]  SHIFT_3LANE       = 5'h06;  // bits per link cycle, three lanes

  typedef enum logic [2:0] {
    SPC_OFF,
    SPC_CLK_WAIT,
    SPC_CAL,
    SPC_LOCK,
    SPC_RUN
  } spc_state_t;

  typedef struct packed {
    logic [PIX_W-1:0] rgb;
  } spc_pix_t;

  typedef struct packed {
    logic       enable;
    logic [2:0] mult;
  } spc_pll_ctl_t;

  typedef struct packed {
    logic [2:0] rise;
    logic [2:0] fall;
  } spc_lanes_t;
endpackage

// >>> verilog/spc_sync.sv
// spc_sync: level synchroniser; with FILTER a change counts once the last two stages agree.
// assumes the input is a level that stays put for several destination clock cycles.
`timescale 1ns/100ps
`default_nettype none
module spc_sync #(
  parameter int STAGES = 3,
  parameter bit FILTER = 1'b1
) (
  input  wire logic clk,      // destination clock
  input  wire logic rst,      // async reset, active high
  input  wire logic d,        // asynchronous level
  output logic      q         // synchronised level
);
  typedef struct packed {
    logic [STAGES-1:0] chain;
    logic              out;
  } st_t;
  st_t st_ff, nxt_st;

  initial begin
    if (STAGES < 2 || (FILTER && STAGES < 3)) begin
      $error("spc_sync: too few stages");
    end
  end

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.chain = {st_ff.chain[STAGES-2:0], d};
    // first stage only feeds the second
    if (!FILTER || st_ff.chain[STAGES-1] == st_ff.chain[STAGES-2]) begin
      nxt_st.out = st_ff.chain[STAGES-1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.out;
endmodule
`default_nettype wire

// >>> verilog/spc_fifo.sv
// spc_fifo: dual-clock FIFO with gray-coded pointers, valid/ready on both sides.
// assumes DEPTH is a power of two; write ready is registered and gated by w_en.
`timescale 1ns/100ps
`default_nettype none
module spc_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 16
) (
  input  wire logic         w_clk,    // write clock
  input  wire logic         r_clk,    // read clock
  input  wire logic         rst,      // async reset, active high
  input  wire logic         w_en,     // next-cycle write permission
  input  wire logic         w_valid,  // write data valid
  input  wire logic [W-1:0] w_data,   // write data
  output logic              w_ready,  // registered room and permission
  output logic              r_valid,  // data available
  output logic [W-1:0]      r_data,   // head word
  input  wire logic         r_ready   // reader takes head word
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin
      $error("spc_fifo: DEPTH must be a power of two, at least 4");
    end
  end

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] rg1;
    logic [AW:0] rg2;
    logic        ready;
  } wst_t;
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] wg1;
    logic [AW:0] wg2;
  } rst_t;

  wst_t         w_ff, nxt_w;
  rst_t         r_ff, nxt_r;
  logic [W-1:0] mem [DEPTH];
  logic         wr;
  logic         rd;

  assign wr = w_valid && w_ff.ready;
  assign rd = r_ready && r_valid;

  always_comb begin
    nxt_w       = w_ff;
    nxt_w.rg1   = r_ff.gray;
    nxt_w.rg2   = w_ff.rg1;
    nxt_w.bin   = w_ff.bin + {{AW{1'b0}}, wr};
    nxt_w.gray  = (nxt_w.bin >> 1) ^ nxt_w.bin;
    // full lags the reader by the sync, so room is never overstated
    nxt_w.ready = w_en && (nxt_w.gray != {~w_ff.rg2[AW:AW-1], w_ff.rg2[AW-2:0]});
  end

  always_comb begin
    nxt_r      = r_ff;
    nxt_r.wg1  = w_ff.gray;
    nxt_r.wg2  = r_ff.wg1;
    nxt_r.bin  = r_ff.bin + {{AW{1'b0}}, rd};
    nxt_r.gray = (nxt_r.bin >> 1) ^ nxt_r.bin;
  end

  always_ff @(posedge w_clk or posedge rst) begin
    if (rst) begin
      w_ff <= '0;
    end else begin
      w_ff <= nxt_w;
    end
  end

  always_ff @(posedge w_clk) begin
    if (wr) begin
      mem[w_ff.bin[AW-1:0]] <= w_data;
    end
  end

  always_ff @(posedge r_clk or posedge rst) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign w_ready = w_ff.ready;
  assign r_valid = (r_ff.gray != r_ff.wg2);
  assign r_data  = mem[r_ff.bin[AW-1:0]];
endmodule
`default_nettype wire

// >>> verilog/spc_top.sv
// spc_top: power-down and clock control of the link transmitter, with pixel FIFO and lane serializer.
// assumes ref_clk at 100 MHz, link_clk from the multiplying PLL, pixel words from ref_clk logic.
`timescale 1ns/100ps
`default_nettype none
module spc_top
  import spc_pkg::*;
#(
  parameter int STOP_CYC   = spc_pkg::STOP_TIMEOUT_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic            ref_clk,      // 100 MHz control clock
  input  wire logic            rst,          // async reset, active high
  input  wire logic            link_clk,     // link clock from the PLL
  input  wire logic            sleep_n,      // power-down pin, active low
  input  wire logic            pixel_clk,    // pixel clock pin, sampled
  input  wire logic [2:0]      lane_cfg,     // lane configuration field
  input  wire logic            pll_locked,   // PLL lock, asynchronous
  input  wire logic            rx_cal_done,  // receiver calibration done, asynchronous
  input  wire spc_pkg::spc_pix_t pix_data,   // pixel word
  input  wire logic            pix_valid,    // pixel word valid
  output logic                 pix_ready,    // pixel word accepted
  output spc_pkg::spc_pll_ctl_t pll_ctl,     // PLL enable and multiplier
  output logic                 rx_cal_req,   // calibration request
  output logic                 power_down,   // transmitter powered down
  output logic                 video_on,     // video transmission allowed
  output logic                 dither_en,    // dithering enable
  output logic                 lut_en,       // color lookup table enable
  output spc_pkg::spc_lanes_t  lanes,        // serial data lanes, rise and fall bits
  output logic                 link_active   // a pixel word is on the lanes
);
  import spc_pkg::*;

  localparam int CW = $clog2(STOP_CYC + 1);
  // counter saturates here: clock parked
  localparam logic [CW-1:0] STOP_LAST = CW'(STOP_CYC);

  initial begin
    if (STOP_CYC < STOP_GAP_PERIODS) begin
      $error("spc_top: stop timeout shorter than the least stop gap");
    end
    if (PIX_W != 2 * 2 * int'(MULT_2LANE) || PIX_W != 2 * 3 * int'(MULT_3LANE)) begin
      $error("spc_top: pixel width does not fit the lane multipliers");
    end

    if (int'(SHIFT_2LANE) != 2 * 2 || int'(SHIFT_3LANE) != 2 * 3) begin
      $error("spc_top: shift is not two bits per lane");
    end

    // edges is two bits wide
    if (FIFO_DEPTH < 4 || CLK_ALIVE_EDGES > 3) begin
      $error("spc_top: buffer or edge count out of range");
    end
  end

  // control domain state
  // three_lane is latched while in CLK_WAIT, waiting for pixel clock edges
  // edges saturates at the alive count
  typedef struct packed {
    spc_state_t   state;
    logic [CW-1:0] idle_cnt;
    logic         pclk_q;
    logic [1:0]   edges;
    logic         three_lane;
    spc_pll_ctl_t pll;
    logic         cal_req;
    logic         pd;
    logic         video;
    logic         dither;
    logic         color_lookup_table;
  } cst_t;

  // link domain state
  // sh holds the bits not yet sent, msb first
  // cnt counts the link cycles left in a word
  typedef struct packed {
    logic [PIX_W-1:0] sh;
    logic [2:0]       cnt;
    spc_lanes_t       lanes;
    logic             active;
    logic             three;
  } lst_t;

  cst_t             c_ff, nxt_c;
  lst_t             l_ff, nxt_l;
  logic             sleep_s;
  logic             pclk_s;
  logic             locked_s;
  logic             cal_s;
  logic             run_l;
  logic             three_l;
  logic             stopped;
  logic             pclk_edge;
  logic             fifo_w_ready;
  logic             fifo_r_valid;
  logic [PIX_W-1:0] fifo_r_data;
  logic             fifo_r_ready;
  logic             wr_en_next;
  logic             alive;
  logic             cfg_three;

  // async pins: filtered, four cycles later
  spc_sync #(.STAGES(3), .FILTER(1'b1)) u_sync_sleep (
    .clk (ref_clk),
    .rst (rst),
    .d   (sleep_n),
    .q   (sleep_s)
  );

  spc_sync #(.STAGES(3), .FILTER(1'b1)) u_sync_pclk (
    .clk (ref_clk),
    .rst (rst),
    .d   (pixel_clk),
    .q   (pclk_s)
  );

  // far-side flags may change at any time
  spc_sync #(.STAGES(3), .FILTER(1'b1)) u_sync_lock (
    .clk (ref_clk),
    .rst (rst),
    .d   (pll_locked),
    .q   (locked_s)
  );

  spc_sync #(.STAGES(3), .FILTER(1'b1)) u_sync_cal (
    .clk (ref_clk),
    .rst (rst),
    .d   (rx_cal_done),
    .q   (cal_s)
  );

  // control levels into the link domain; lane count only changes while video is off
  spc_sync #(.STAGES(2), .FILTER(1'b0)) u_sync_run (
    .clk (link_clk),
    .rst (rst),
    .d   (c_ff.video),
    .q   (run_l)
  );

  spc_sync #(.STAGES(2), .FILTER(1'b0)) u_sync_three (
    .clk (link_clk),
    .rst (rst),
    .d   (c_ff.three_lane),
    .q   (three_l)
  );

  assign pclk_edge = (pclk_s != c_ff.pclk_q);
  assign stopped   = (c_ff.idle_cnt == STOP_LAST);
  assign alive     = (c_ff.edges == 2'(CLK_ALIVE_EDGES));

  // reserved patterns mean two lanes
  assign cfg_three = (lane_cfg == LANE_CFG_3);

  always_comb begin
    nxt_c        = c_ff;
    nxt_c.pclk_q = pclk_s;
    // counts reference cycles since the last pixel clock edge
    // a four-period gap stays below the timeout
    if (pclk_edge) begin
      nxt_c.idle_cnt = '0;
    end else if (!stopped) begin
      nxt_c.idle_cnt = c_ff.idle_cnt + CW'(1);
    end

    // OFF: pin asleep
    // CLK_WAIT: down, counting edges
    // CAL: receiver calibrating
    // LOCK: PLL settling
    // RUN: words flow
    unique case (c_ff.state)
      SPC_OFF: begin
        // wake-up always counts from zero
        nxt_c.edges = '0;
        if (sleep_s) begin
          nxt_c.state = SPC_CLK_WAIT;
        end
      end
      SPC_CLK_WAIT: begin
        // host may still reconfigure lanes while the clock is static
        nxt_c.three_lane = cfg_three;
        if (pclk_edge && !alive) begin
          nxt_c.edges = c_ff.edges + 2'h1;
        end
        // two edges: a real clock, not a stray
        if (alive) begin
          nxt_c.state = SPC_CAL;
        end
      end
      SPC_CAL: begin
        // PLL already runs so the receiver sees a live clock
        if (cal_s) begin
          nxt_c.state = SPC_LOCK;
        end
      end
      SPC_LOCK: begin
        // video only once lock holds, after calibration has finished
        if (locked_s) begin
          nxt_c.state = SPC_RUN;
        end
      end
      SPC_RUN: begin
        // a lost lock stops video until the PLL settles again
        if (!locked_s) begin
          nxt_c.state = SPC_LOCK;
        end
      end
      default: begin
        nxt_c.state = SPC_OFF;
      end
    endcase

    // pixel clock parked at a level: automatic power-down
    if (stopped && c_ff.state != SPC_OFF && c_ff.state != SPC_CLK_WAIT) begin
      nxt_c.state = SPC_CLK_WAIT;
      nxt_c.edges = '0;
    end
    // sleep pin low wins over everything
    if (!sleep_s) begin
      nxt_c.state = SPC_OFF;
    end

    // outputs follow the next state
    nxt_c.pd         = (nxt_c.state == SPC_OFF || nxt_c.state == SPC_CLK_WAIT);
    nxt_c.cal_req    = (nxt_c.state == SPC_CAL);
    nxt_c.pll.enable = !nxt_c.pd;
    nxt_c.pll.mult   = nxt_c.three_lane ? MULT_3LANE : MULT_2LANE;
    nxt_c.video      = (nxt_c.state == SPC_RUN);

    // image features stay off; nothing here turns them on
    nxt_c.dither     = 1'b0;
    nxt_c.color_lookup_table        = 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c_ff          <= '0;
      c_ff.state    <= SPC_OFF;
      c_ff.pd       <= 1'b1;
      // multiplier starts at the two-lane value
      c_ff.pll.mult <= MULT_2LANE;
    end else begin
      c_ff <= nxt_c;
    end
  end

  // fifo takes words only while video runs; ready is registered inside
  // next state is used so ready falls together with video_on
  assign wr_en_next = (nxt_c.state == SPC_RUN);

  // the gray-coded buffer is the crossing into the link domain
  spc_fifo #(.W(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .w_clk   (ref_clk),
    .r_clk   (link_clk),
    .rst     (rst),
    .w_en    (wr_en_next),
    .w_valid (pix_valid),
    .w_data  (pix_data.rgb),
    .w_ready (fifo_w_ready),
    .r_valid (fifo_r_valid),
    .r_data  (fifo_r_data),
    .r_ready (fifo_r_ready)
  );

  // a word starts only on a word boundary and only while video runs
  // so only a parked link clock can split a word between two runs
  assign fifo_r_ready = (l_ff.cnt == 3'h0) && run_l && fifo_r_valid;

  // lane mode is taken at the start of a word and kept to its end, so
  // a word cut by a parked link clock resumes in the mode it began in
  always_comb begin
    logic [PIX_W-1:0] word;
    logic [4:0]       shift;
    logic             mode;
    word          = '0;
    mode          = (l_ff.cnt == 3'h0) ? three_l : l_ff.three;
    shift         = mode ? SHIFT_3LANE : SHIFT_2LANE;

    nxt_l         = l_ff;
    // lanes rest at zero between words
    nxt_l.lanes   = '0;
    nxt_l.active  = 1'b0;
    if (l_ff.cnt != 3'h0 || fifo_r_ready) begin
      word = (l_ff.cnt == 3'h0) ? fifo_r_data : l_ff.sh;
      // two bits per lane each link cycle: one for the rising, one for the falling edge
      if (mode) begin
        nxt_l.lanes.rise = word[PIX_W-1 -: 3];
        nxt_l.lanes.fall = word[PIX_W-4 -: 3];
        nxt_l.cnt        = (l_ff.cnt == 3'h0) ? MULT_3LANE - 3'h1 : l_ff.cnt - 3'h1;
      end else begin
        nxt_l.lanes.rise = {1'b0, word[PIX_W-1 -: 2]};
        nxt_l.lanes.fall = {1'b0, word[PIX_W-3 -: 2]};
        nxt_l.cnt        = (l_ff.cnt == 3'h0) ? MULT_2LANE - 3'h1 : l_ff.cnt - 3'h1;
      end
      nxt_l.three  = mode;
      nxt_l.sh     = word << shift;
      nxt_l.active = 1'b1;
    end
  end

  // link clock may stop with the PLL; a word then resumes where it stood
  // no link reset of its own: rst is asynchronous and reaches both domains
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      l_ff <= '0;
    end else begin
      l_ff <= nxt_l;
    end
  end


  // every output is a flop of one of the two domains
  assign pix_ready   = fifo_w_ready;
  assign pll_ctl     = c_ff.pll;
  assign rx_cal_req  = c_ff.cal_req;
  assign power_down  = c_ff.pd;
  assign video_on    = c_ff.video;
  assign dither_en   = c_ff.dither;
  assign lut_en      = c_ff.color_lookup_table;
  assign lanes       = l_ff.lanes;
  assign link_active = l_ff.active;
endmodule
`default_nettype wire

// >>> bench/spc_top_asserts.sv
// spc_top_asserts: port checker for spc_top, bound after the module.
// assumes ref_clk and link_clk domains sharing the async rst.
`timescale 1ns/100ps
`default_nettype none
module spc_top_asserts
  import spc_pkg::*;
#(
  parameter int STOP_CYC = spc_pkg::STOP_TIMEOUT_CYC
) (
  input wire logic                  ref_clk,     // control clock
  input wire logic                  rst,         // async reset
  input wire logic                  link_clk,    // link clock
  input wire logic                  sleep_n,     // power-down pin
  input wire logic                  pixel_clk,   // pixel clock pin
  input wire logic [2:0]            lane_cfg,    // lane field
  input wire logic                  pll_locked,  // lock flag
  input wire logic                  rx_cal_done, // calibrated flag
  input wire logic                  pix_ready,   // pixel ready
  input wire spc_pkg::spc_pll_ctl_t pll_ctl,     // PLL control
  input wire logic                  rx_cal_req,  // calibration request
  input wire logic                  power_down,  // powered down
  input wire logic                  video_on,    // video allowed
  input wire spc_pkg::spc_lanes_t   lanes,       // lane bits
  input wire logic                  link_active  // word on lanes
);
  import spc_pkg::*;
  int   still_ff;
  logic pix_q_ff;
  // raw pin age; the design sees the pin later, so this never understates
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      still_ff <= 0;
      pix_q_ff <= 1'b0;
    end else begin
      pix_q_ff <= pixel_clk;
      still_ff <= (pixel_clk != pix_q_ff) ? 0 : still_ff + 1;
    end
  end
  sequence s_sleep_low;
    !sleep_n [*6];
  endsequence
  sequence s_powered_up;
    rx_cal_req && pll_ctl.enable && !video_on;
  endsequence
  property p_sleep;
    @(posedge ref_clk) disable iff (rst) s_sleep_low |-> power_down && !video_on && !pll_ctl.enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("still up with sleep_n low");
  property p_up;
    @(posedge ref_clk) disable iff (rst) $fell(power_down) |-> s_powered_up;
  endproperty
  a_up: assert property (p_up) else $error("power-up did not start calibration");
  property p_cal;
    @(posedge ref_clk) disable iff (rst) $fell(rx_cal_req) && !power_down |-> $past(rx_cal_done, 3);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration left early");
  property p_lock;
    @(posedge ref_clk) disable iff (rst) $rose(video_on) |-> $past(pll_locked, 3);
  endproperty
  a_lock: assert property (p_lock) else $error("video without lock");
  property p_ready;
    @(posedge ref_clk) disable iff (rst) pix_ready |-> video_on;
  endproperty
  a_ready: assert property (p_ready) else $error("pixels taken outside run");
  property p_mult;
    @(posedge ref_clk) disable iff (rst)
      $rose(pll_ctl.enable) |-> pll_ctl.mult == (($past(lane_cfg, 2) == LANE_CFG_3) ? MULT_3LANE : MULT_2LANE);
  endproperty
  a_mult: assert property (p_mult) else $error("wrong link clock multiplier");
  property p_auto_pd;
    @(posedge ref_clk) disable iff (rst) still_ff >= STOP_CYC + 8 |-> power_down;
  endproperty
  a_auto_pd: assert property (p_auto_pd) else $error("no power-down on parked clock");
  property p_no_early_pd;
    @(posedge ref_clk) disable iff (rst) $rose(power_down) && sleep_n && $past(sleep_n, 8) |-> still_ff >= STOP_CYC;
  endproperty
  a_no_early_pd: assert property (p_no_early_pd) else $error("power-down on a short gap");
  property p_idle;
    @(posedge link_clk) disable iff (rst) !link_active |-> lanes == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("lanes busy without a word");
endmodule
bind spc_top spc_top_asserts #(.STOP_CYC(STOP_CYC)) u_chk (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
  .sleep_n(sleep_n), .pixel_clk(pixel_clk), .lane_cfg(lane_cfg), .pll_locked(pll_locked),
  .rx_cal_done(rx_cal_done), .pix_ready(pix_ready), .pll_ctl(pll_ctl), .rx_cal_req(rx_cal_req),
  .power_down(power_down), .video_on(video_on), .lanes(lanes), .link_active(link_active));
`default_nettype wire

// >>> bench/spc_far_model.sv
// spc_far_model: PLL clock source and receiver model at the link end.
// assumes lanes change on rising link edges; bits are taken on falling ones.
`timescale 1ns/100ps
`default_nettype none
module spc_far_model
  import spc_pkg::*;
#(
  parameter int CAL_NS  = 600,
  parameter int LOCK_NS = 900
) (
  input  wire logic                  rst,         // async reset
  input  wire logic                  hold,        // stall, link clock parked
  input  wire spc_pkg::spc_pll_ctl_t pll_ctl,     // PLL control
  input  wire logic                  rx_cal_req,  // calibration request
  input  wire spc_pkg::spc_lanes_t   lanes,       // lane bits
  input  wire logic                  link_active, // word on lanes
  output logic                       link_clk,    // link clock
  output logic                       pll_locked,  // lock flag
  output logic                       rx_cal_done  // calibrated flag
);
  import spc_pkg::*;
  logic [23:0] acc;
  logic [23:0] got[$];
  int          n;
  initial begin
    link_clk = 1'b0;
    pll_locked = 1'b0;
    rx_cal_done = 1'b0;
    acc = '0;
    n = 0;
  end
  // 80 ns link period, parked on hold or when the PLL is off outside reset
  always begin
    if ((pll_ctl.enable || rst) && !hold) #40 link_clk = ~link_clk;
    else begin
      if (link_clk) #40;
      link_clk = 1'b0;
      wait ((pll_ctl.enable || rst) && !hold);
      #3;
    end
  end
  // answers only after a real delay
  always @(pll_ctl.enable) begin
    if (pll_ctl.enable) #LOCK_NS pll_locked = pll_ctl.enable;
    else pll_locked = 1'b0;
  end
  always @(rx_cal_req) begin
    if (rx_cal_req) #CAL_NS rx_cal_done = rx_cal_req;
    else rx_cal_done = 1'b0;
  end
  always @(negedge link_clk) begin
    if (link_active) begin
      if (pll_ctl.mult != MULT_3LANE) acc = {acc[19:0], lanes.rise[1:0], lanes.fall[1:0]};
      else acc = {acc[17:0], lanes.rise, lanes.fall};
      n = n + 1;
      if (n == ((pll_ctl.mult != MULT_3LANE) ? 6 : 4)) begin
        got.push_back(acc);
        n = 0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/spc_top_bench.sv
// spc_top_bench: self-checking bench of spc_top with the link-end model.
// assumes spc_far_model answers lock, calibration and makes link_clk.
`timescale 1ns/100ps
`default_nettype none
module spc_top_bench;
  import spc_pkg::*;
  typedef struct packed {
    logic [2:0]  cfg;
    logic [2:0]  mult;
    logic [23:0] word;
  } spc_row_t;
  localparam int STOP  = 40;
  localparam int DEPTH = 16;
  logic         ref_clk, rst, link_clk, sleep_n, pixel_clk, pll_locked, rx_cal_done, pix_valid;
  logic         pix_ready, rx_cal_req, power_down, video_on, dither_en, lut_en, link_active;
  logic         pix_run, link_hold;
  logic [2:0]   lane_cfg;
  spc_pix_t     pix_data;
  spc_pll_ctl_t pll_ctl;
  spc_lanes_t   lanes;
  int           num_errors, cmp_count, i, n, seen, div;
  // reserved patterns fall back to two lanes; the last two rows use reserved patterns
  spc_row_t rows [4] = '{'{LANE_CFG_2, MULT_2LANE, 24'ha5c3e1}, '{LANE_CFG_3, MULT_3LANE, 24'h3c5a96},
                         '{3'h0, MULT_2LANE, 24'h0f1e2d}, '{3'h7, MULT_2LANE, 24'hf0e1d2}};
  spc_top #(.STOP_CYC(STOP), .FIFO_DEPTH(DEPTH)) DUT (
    .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .sleep_n(sleep_n), .pixel_clk(pixel_clk),
    .lane_cfg(lane_cfg), .pll_locked(pll_locked), .rx_cal_done(rx_cal_done), .pix_data(pix_data),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pll_ctl(pll_ctl), .rx_cal_req(rx_cal_req),
    .power_down(power_down), .video_on(video_on), .dither_en(dither_en), .lut_en(lut_en),
    .lanes(lanes), .link_active(link_active));
  spc_far_model far (.rst(rst), .hold(link_hold), .pll_ctl(pll_ctl), .rx_cal_req(rx_cal_req),
    .lanes(lanes), .link_active(link_active), .link_clk(link_clk), .pll_locked(pll_locked),
    .rx_cal_done(rx_cal_done));
  always #5 ref_clk = ~ref_clk;
  // 40 ns pixel clock; stops cleanly at a driven level
  always @(negedge ref_clk) begin
    if (pix_run) begin
      div = div + 1;
      if (div[0]) pixel_clk <= ~pixel_clk;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_test(input string what);
    $display("test done: %s", what);
  endtask
  task automatic wait_video();
    int k;
    k = 0;
    while (video_on !== 1'b1 && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    chk("video_on", 1, video_on);
  endtask
  task automatic wait_words(input int cnt);
    int k;
    k = 0;
    while (far.got.size() < cnt && k < 2000) begin
      @(negedge ref_clk);
      k++;
    end
    chk("word_count", cnt, far.got.size());
  endtask
  task automatic send(input logic [23:0] w);
    pix_data.rgb = w;
    pix_valid = 1'b1;
    while (pix_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    pix_valid = 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // whole run needs about 2000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    finish_test();
  end
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    sleep_n = 1'b0;
    pixel_clk = 1'b0;
    pix_run = 1'b0;
    link_hold = 1'b0;
    lane_cfg = LANE_CFG_2;
    pix_data = '0;
    pix_valid = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    div = 0;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    for (i = 0; i < 4; i++) begin
      sleep_n = 1'b0;
      pix_run = 1'b0;
      repeat (10) @(negedge ref_clk);
      chk("power_down", 1, power_down);
      lane_cfg = rows[i].cfg;
      sleep_n = 1'b1;
      repeat (10) @(negedge ref_clk);
      pix_run = 1'b1;
      wait_video();
      chk("mult", rows[i].mult, pll_ctl.mult);
      chk("power_down", 0, power_down);
      far.got.delete();
      send(rows[i].word);
      wait_words(1);
      chk("word", rows[i].word, far.got[0]);
      end_test("lane config row");
    end
    // gap of exactly four pixel periods must not power down
    pix_run = 1'b0;
    seen = 0;
    for (i = 0; i < 30; i++) begin
      if (i == 16) pix_run = 1'b1;
      if (power_down !== 1'b0) seen++;
      @(negedge ref_clk);
    end
    chk("early_power_down", 0, seen);
    end_test("short clock gap");
    pix_run = 1'b0;
    repeat (60) @(negedge ref_clk);
    chk("power_down", 1, power_down);
    chk("video_on", 0, video_on);
    far.got.delete();
    pix_run = 1'b1;
    wait_video();
    send(24'h5a5a5a);
    wait_words(1);
    chk("word", 24'h5a5a5a, far.got[0]);
    end_test("clock stop and restart");
    // far side stalls while the buffer fills
    link_hold = 1'b1;
    far.got.delete();
    repeat (4) @(negedge ref_clk);
    n = 0;
    pix_data.rgb = 24'h100000;
    pix_valid = 1'b1;
    for (i = 0; i < 40; i++) begin
      if (pix_ready === 1'b1) n++;
      @(negedge ref_clk);
      pix_data.rgb = 24'h100000 + 24'(n);
    end
    pix_valid = 1'b0;
    chk("fifo_fill", DEPTH, n);
    link_hold = 1'b0;
    wait_words(DEPTH);
    for (i = 0; i < DEPTH; i++) chk("fifo_word", 24'h100000 + 24'(i), far.got[i]);
    end_test("fifo fill and drain");
    rst = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk("power_down", 1, power_down);
    chk("pll_ctl", {1'b0, MULT_2LANE}, pll_ctl);
    chk("video_pix_ready", 0, {video_on, pix_ready});
    chk("dither_lut", 0, {dither_en, lut_en});
    chk("rx_cal_req", 0, rx_cal_req);
    chk("lanes", 0, lanes);
    rst = 1'b0;
    end_test("reset");
    finish_test();
  end
endmodule
`default_nettype wire
